// File: tb/lpfs_chk.sv
// Purpose: port checker of the power-up and fault sequencer
// Assumes: counts follow the parameters of the bound instance
// Notes: counters are helper logic, not design state
`timescale 1ns/1ns
module lpfs_chk #(
  parameter int MOD_OC_CYC = 10000,
  parameter int EN_LOW_CYC = 32750
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable_in,
  input lpfs_pkg::lpfs_cmp_t cmp_in,
  input wire logic disconnect_gate_on,
  input wire logic [3:0] led_sink_en,
  input wire logic full_shutdown
);
  import lpfs_pkg::*;
  logic [15:0] oc_cnt, el_cnt, gon_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // overcurrent time with gate on
  always_ff @(posedge mclk) begin
    if (srst || !disconnect_gate_on || !cmp_in.current_sense_trip) oc_cnt <= 16'h0000;
    else if (oc_cnt != 16'hffff) oc_cnt <= oc_cnt + 16'h0001;
  end
  // enable low time with gate on
  always_ff @(posedge mclk) begin
    if (srst || !disconnect_gate_on || enable_in) el_cnt <= 16'h0000;
    else if (el_cnt != 16'hffff) el_cnt <= el_cnt + 16'h0001;
  end
  // gate on time, saturating
  always_ff @(posedge mclk) begin
    if (srst || !disconnect_gate_on) gon_cnt <= 16'h0000;
    else if (gon_cnt != 16'hffff) gon_cnt <= gon_cnt + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fs_off;
    cmp_in.freq_set_sync_pin_low [*4] ##0 !disconnect_gate_on;
  endsequence
  sequence s_dbl;
    (disconnect_gate_on && cmp_in.current_sense_double_trip) [*3];
  endsequence
  property p_sink_gate; |led_sink_en |-> disconnect_gate_on; endproperty
  a_sink_gate: assert property (p_sink_gate) else $error("sinks on without gate");
  property p_fs_hold; s_fs_off |=> !disconnect_gate_on; endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("start with freq pin low");
  property p_start_en;
    $rose(disconnect_gate_on) |-> $past(enable_in, 3) && $past(enable_in, 20);
  endproperty
  a_start_en: assert property (p_start_en) else $error("start on short enable");
  property p_start_uv;
    $rose(disconnect_gate_on) |-> $past(cmp_in.supply_undervoltage_lockout_clear, 3);
  endproperty
  a_start_uv: assert property (p_start_uv) else $error("start under lockout");
  property p_gate_lvl; $rose(|led_sink_en) |-> cmp_in.gate_at_level; endproperty
  a_gate_lvl: assert property (p_gate_lvl) else $error("run without gate level");
  property p_det_delay; $rose(|led_sink_en) |-> gon_cnt > 16'h0dac; endproperty
  a_det_delay: assert property (p_det_delay) else $error("detect delay too short");
  property p_in_use;
    |led_sink_en |-> (led_sink_en & ~cmp_in.led_sink_pin_in_use) == 4'h0;
  endproperty
  a_in_use: assert property (p_in_use) else $error("unused sink enabled");
  property p_dbl; s_dbl |=> !disconnect_gate_on; endproperty
  a_dbl: assert property (p_dbl) else $error("double trip too slow");
  property p_mod; oc_cnt <= MOD_OC_CYC + 4; endproperty
  a_mod: assert property (p_mod) else $error("moderate trip too slow");
  property p_en_low; $rose(full_shutdown) |-> $past(el_cnt) >= EN_LOW_CYC; endproperty
  a_en_low: assert property (p_en_low) else $error("shutdown too early");
endmodule
bind lpfs_top lpfs_chk #(.MOD_OC_CYC(MOD_OC_CYC), .EN_LOW_CYC(EN_LOW_CYC)) chk_u (
  .mclk(mclk), .srst(srst), .enable_in(enable_in), .cmp_in(cmp_in),
  .disconnect_gate_on(disconnect_gate_on), .led_sink_en(led_sink_en),
  .full_shutdown(full_shutdown));

// File: tb/lpfs_far.sv
// Purpose: far side of the sequencer: gate and LED pin comparators
// Assumes: gate reaches its level gdly cycles after the driver turns on
// Notes: shorted pins never rise above the detect level
`timescale 1ns/1ns
module lpfs_far (
  input wire logic mclk,
  input wire logic gate_on,
  input wire logic [3:0] gdly,
  input wire logic [3:0] misc,
  input wire logic [3:0] sh,
  input wire logic [3:0] iu,
  output lpfs_pkg::lpfs_cmp_t cmp
);
  import lpfs_pkg::*;
  logic [3:0] gcnt;
  logic lvl;
  always_ff @(posedge mclk) begin
    if (!gate_on) gcnt <= 4'h0;
    else if (gcnt != gdly) gcnt <= gcnt + 4'h1;
  end
  assign lvl = gate_on && gcnt == gdly;
  assign cmp = '{misc[3], misc[2], lvl, misc[1], misc[0], lvl ? ~sh : 4'h0, sh, iu & ~sh};
endmodule

// File: tb/tb_top.sv
// Purpose: self-checking bench of the power-up and fault sequencer
// Assumes: short counts 20 and 40 stand in for the long ones
// Notes: est models the sticky status word
`timescale 1ns/1ns
`include "lpfs_consts.svh"
`define CK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import lpfs_pkg::*;
  logic mclk = 0, srst = 1, en = 0, avs_read = 0, avs_write = 0, wrq, gate, fsd, irq;
  logic [3:0] avs_address = 0, gdly = 1, misc = 0, sh = 0, iu = 0, sinks, e4;
  logic [31:0] avs_writedata = 0, rdata, q;
  logic [15:0] lf = 16'h3b14;
  lpfs_cmp_t cmp;
  int mismatches = 0, n_tests = 0, est = 0;
  always #20 mclk = ~mclk;
  lpfs_top #(.MOD_OC_CYC(20), .EN_LOW_CYC(40)) dut_u (.mclk(mclk), .srst(srst),
    .enable_in(en), .cmp_in(cmp), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(rdata),
    .avs_waitrequest(wrq), .disconnect_gate_on(gate), .led_sink_en(sinks),
    .full_shutdown(fsd), .irq(irq));
  lpfs_far far_u (.mclk(mclk), .gate_on(gate), .gdly(gdly), .misc(misc), .sh(sh),
    .iu(iu), .cmp(cmp));
  ////////////////////////////////////////////////////////////////////////////
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task cyc(input int n); repeat (n) @(posedge mclk); endtask
  // request held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
    @(posedge mclk);
    while (wrq !== 1'b0) @(posedge mclk);
    q = rdata;
    avs_write <= 1'b0; avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e); bus(0, a, 0); `CK("reg", e, q) endtask
  task rdst; rd(`LPFS_ADDR_STATUS, est); est = 0; endtask
  task wg(input logic v);
    for (int i = 0; i < 400 && gate !== v; i++) @(posedge mclk);
    `CK("gate", v, gate)
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, run needs about 11000 cycles
  initial begin cyc(40000); mismatches++; close_out; end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20); srst <= 1'b0; cyc(1);
    rd(`LPFS_ADDR_CTRL, 32'h0000_0001); rd(`LPFS_ADDR_MASK, 0); rd(4'h2, 0);
    bus(1, `LPFS_ADDR_MASK, 32'h0000_003f);
    misc <= 4'b1100; en <= 1'b1; cyc(60); `CK("gate", 1'b0, gate)
    misc <= 4'b1000; wg(1);
    lf = lfsr(lf); e4 = lf[3:0] | 4'h1; iu <= e4;
    cyc(3400); `CK("sinks", 4'h0, sinks)
    cyc(200); `CK("sinks", e4, sinks)
    `CK("irq", 1'b1, irq)
    est = 32 | (e4 != 4'hf ? 2 : 0); rdst; rdst; cyc(2);
    `CK("irq", 1'b0, irq)
    misc <= 4'b1001; cyc(4); `CK("gate", 1'b0, gate)
    `CK("sinks", 4'h0, sinks)
    misc <= 4'b1000; gdly <= 4'ha; est = 4; rdst; cyc(30); `CK("gate", 1'b0, gate)
    en <= 1'b0; cyc(4); en <= 1'b1; wg(1);
    misc <= 4'b1010; cyc(15); `CK("gate", 1'b1, gate)
    cyc(10); `CK("gate", 1'b0, gate)
    en <= 1'b0; misc <= 4'b1000; est = 8; rdst;
    sh <= 4'b0010; iu <= 4'b1101; gdly <= 4'h1; en <= 1'b1; wg(1);
    cyc(3600); `CK("sinks", 4'h0, sinks)
    bus(0, `LPFS_ADDR_STATE, 0); `CK("state", 6'h08, q[5:0])
    est = 1; rdst; sh <= 4'h0;
    cyc(3600); `CK("sinks", 4'b1101, sinks)
    est = 34; rdst;
    en <= 1'b0; cyc(30); `CK("off", 1'b0, fsd)
    cyc(20); `CK("off", 1'b1, fsd)
    `CK("gate", 1'b0, gate)
    est = 16; rdst;
    bus(1, `LPFS_ADDR_CTRL, 32'h0000_0000); en <= 1'b1; cyc(40); `CK("gate", 1'b0, gate)
    bus(1, `LPFS_ADDR_CTRL, 32'h0000_0001); wg(1);
    bus(1, `LPFS_ADDR_CTRL, 32'h0000_0003); cyc(2); `CK("gate", 1'b0, gate)
    rd(`LPFS_ADDR_CTRL, 32'h0000_0003);
    close_out;
  end
endmodule

// File: verilog/lpfs_consts.svh
// Purpose: constants of the LED driver power-up and fault sequencer
// Assumes: mclk is the switching-oscillator clock at 25 MHz
// Notes: offsets are byte addresses on the Avalon-MM slave
`ifndef LPFS_CONSTS_SVH
`define LPFS_CONSTS_SVH

// clock
`define LPFS_CLK_HZ 25000000
`define LPFS_CLK_NS 40

// first enable pulse, a least time, rounded up
`define LPFS_EN_MIN_HIGH_NS 750
`define LPFS_EN_MIN_HIGH_CYC ((`LPFS_EN_MIN_HIGH_NS + `LPFS_CLK_NS - 1) / `LPFS_CLK_NS)

// double overcurrent trip, a longest time, rounded down
`define LPFS_DBL_OC_MAX_NS 3000
`define LPFS_DBL_OC_MAX_CYC (`LPFS_DBL_OC_MAX_NS / `LPFS_CLK_NS)

// counts in switching cycles
`define LPFS_DET_DELAY_CYC 3500
`define LPFS_MOD_OC_CYC 10000
`define LPFS_EN_LOW_CYC 32750

// register offsets
`define LPFS_ADDR_CTRL 4'h0
`define LPFS_ADDR_STATUS 4'h4
`define LPFS_ADDR_MASK 4'h8
`define LPFS_ADDR_STATE 4'hC

// control fields
`define LPFS_CTRL_ALLOW 0
`define LPFS_CTRL_FORCE_OFF 1

// status and mask fields
`define LPFS_ST_SHORT 0
`define LPFS_ST_UNUSED 1
`define LPFS_ST_OC_FAST 2
`define LPFS_ST_OC_SLOW 3
`define LPFS_ST_EN_LOW 4
`define LPFS_ST_RUN 5
`define LPFS_EV_W 6

// state register fields
`define LPFS_SR_STATE_LSB 0
`define LPFS_SR_USED_LSB 8
`define LPFS_SR_SHORT_LSB 12

// reset values
`define LPFS_CTRL_RST 32'h0000_0001
`define LPFS_MASK_RST 32'h0000_0000

`endif

// File: verilog/lpfs_pkg.sv
// Purpose: types of the LED driver power-up and fault sequencer
// Assumes: nothing beyond the constants header
// Notes: state codes are one-hot
package lpfs_pkg;

  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_GATE = 6'b00_0010,
    ST_DETECT = 6'b00_0100,
    ST_SHORT = 6'b00_1000,
    ST_RUN = 6'b01_0000,
    ST_OFF = 6'b10_0000
  } lpfs_state_t;

  // analog comparator results
  typedef struct packed {
    logic supply_undervoltage_lockout_clear;
    logic freq_set_sync_pin_low;
    logic gate_at_level;
    logic current_sense_trip;
    logic current_sense_double_trip;
    logic [3:0] led_sink_pin_above_detect;
    logic [3:0] led_sink_pin_shorted;
    logic [3:0] led_sink_pin_in_use;
  } lpfs_cmp_t;

endpackage

// File: verilog/lpfs_top.sv
// Purpose: power-up and input fault sequencer of a four-channel LED driver
// Assumes: mclk is the switching-oscillator clock; comparators arrive raw
// Notes: soft start, sync clock handling and dimming are outside this block
//
// What this block does
// - start only after enable high for minimum time and lockout cleared
// - check for faults before any LED sink is enabled
// - frequency pin held low keeps the block unpowered
// - lockout cleared and enable high: gate driver on, then pin checks
// - detection starts when gate comparator reports its level
// - wait the detection delay after pin rises before classifying
// - classify pins shorted, unused or in use; short halts power-up
// - double current trip shuts down at once, no counting
// - moderate overcurrent shuts down after its cycle count
// - enable low for its cycle count while the gate driver sequence is under way gives full shutdown
// - hold while a pin is shorted, then recheck all four pins
`timescale 1ns/1ns
`include "lpfs_consts.svh"

module lpfs_top #(
  parameter int MOD_OC_CYC = `LPFS_MOD_OC_CYC,
  parameter int EN_LOW_CYC = `LPFS_EN_LOW_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable_in,
  input lpfs_pkg::lpfs_cmp_t cmp_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic disconnect_gate_on,
  output logic [3:0] led_sink_en,
  output logic full_shutdown,
  output logic irq
);
  import lpfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  lpfs_cmp_t cmp_s1;
  lpfs_cmp_t cmp;
  logic en_s1;
  logic en_s;
  lpfs_state_t state;
  logic [4:0] en_hi_cnt;
  logic [11:0] det_cnt;
  logic [13:0] oc_cnt;
  logic [14:0] en_lo_cnt;
  logic [3:0] pin_used;
  logic [3:0] pin_short;
  logic [31:0] ctrl;
  logic [31:0] mask;
  logic [`LPFS_EV_W-1:0] status;
  logic [`LPFS_EV_W-1:0] ev;
  logic active;
  logic en_hi_ok;
  logic start_ok;
  logic det_done;
  logic any_short;
  logic oc_done;
  logic en_lo_done;
  logic fault;
  logic bus_go;
  logic rd_clear;
  logic rearm_wait;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_s1 <= '0;
      cmp <= '0;
      en_s1 <= 1'b0;
      en_s <= 1'b0;
    end else begin
      cmp_s1 <= cmp_in;
      cmp <= cmp_s1;
      en_s1 <= enable_in;
      en_s <= en_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conditions

  // references powered whenever the gate driver sequence is under way
  assign active = (state == ST_GATE) || (state == ST_DETECT) ||
                  (state == ST_SHORT) || (state == ST_RUN);
  assign en_hi_ok = (en_hi_cnt == 5'(`LPFS_EN_MIN_HIGH_CYC));
  assign start_ok = ctrl[`LPFS_CTRL_ALLOW] && !ctrl[`LPFS_CTRL_FORCE_OFF] &&
                    cmp.supply_undervoltage_lockout_clear &&
                    !cmp.freq_set_sync_pin_low && en_hi_ok && !rearm_wait;
  assign det_done = (state == ST_DETECT) &&
                    (det_cnt == 12'(`LPFS_DET_DELAY_CYC - 1));
  assign any_short = |cmp.led_sink_pin_shorted;
  assign oc_done = (oc_cnt == 14'(MOD_OC_CYC - 1)) && cmp.current_sense_trip;
  assign en_lo_done = (en_lo_cnt == 15'(EN_LOW_CYC - 1)) && !en_s;
  // instant trip, no count
  // a low frequency pin only aborts power-up; in run it is sync handling
  assign fault = active && (cmp.current_sense_double_trip || oc_done ||
                 ctrl[`LPFS_CTRL_FORCE_OFF] ||
                 (cmp.freq_set_sync_pin_low && state != ST_RUN));

  ////////////////////////////////////////////////////////////////////////
  // counters

  // first enable pulse width, saturating
  always_ff @(posedge mclk) begin
    if (srst || !en_s) begin
      en_hi_cnt <= '0;
    end else if (!en_hi_ok) begin
      en_hi_cnt <= en_hi_cnt + 5'd1;
    end
  end

  // fresh enable after fault
  // without it a lasting fault would restart the gate every other cycle
  always_ff @(posedge mclk) begin
    if (srst || !en_s) begin
      rearm_wait <= 1'b0;
    end else if (fault) begin
      rearm_wait <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !active || !cmp.current_sense_trip || oc_done) begin
      oc_cnt <= '0;
    end else begin
      oc_cnt <= oc_cnt + 14'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !active || en_s || en_lo_done) begin
      en_lo_cnt <= '0;
    end else begin
      en_lo_cnt <= en_lo_cnt + 15'd1;
    end
  end

  // delay runs once any pin passes the detect level
  always_ff @(posedge mclk) begin
    if (srst || state != ST_DETECT || det_done) begin
      det_cnt <= '0;
    end else if (det_cnt != 12'd0 || |cmp.led_sink_pin_above_detect) begin
      det_cnt <= det_cnt + 12'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  // faults win over every other move
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else if (fault) begin
      state <= ST_IDLE;
    end else if (active && en_lo_done) begin
      state <= ST_OFF;
    end else begin
      case (state)
        ST_IDLE, ST_OFF: begin
          if (start_ok) begin
            state <= ST_GATE;
          end
        end
        ST_GATE: begin
          if (cmp.gate_at_level) begin
            state <= ST_DETECT;
          end
        end
        ST_DETECT: begin
          if (det_done) begin
            state <= any_short ? ST_SHORT : ST_RUN;
          end
        end
        ST_SHORT: begin
          if (!any_short) begin
            state <= ST_DETECT;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || state == ST_IDLE || state == ST_OFF) begin
      pin_used <= '0;
      pin_short <= '0;
    end else if (det_done) begin
      pin_short <= cmp.led_sink_pin_shorted;
      pin_used <= any_short ? 4'h0 : cmp.led_sink_pin_in_use;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // gate and sinks drop on the fault edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      disconnect_gate_on <= 1'b0;
      led_sink_en <= '0;
      full_shutdown <= 1'b0;
    end else begin
      disconnect_gate_on <= active && !fault && !en_lo_done;
      led_sink_en <= (state == ST_RUN && !fault && en_s) ? pin_used : 4'h0;
      full_shutdown <= (state == ST_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events and interrupt

  // one-cycle event strobes
  always_comb begin
    ev = '0;
    ev[`LPFS_ST_SHORT] = det_done && any_short;
    ev[`LPFS_ST_UNUSED] = det_done && !any_short && !(&cmp.led_sink_pin_in_use);
    ev[`LPFS_ST_OC_FAST] = active && cmp.current_sense_double_trip;
    ev[`LPFS_ST_OC_SLOW] = active && oc_done;
    ev[`LPFS_ST_EN_LOW] = active && en_lo_done && !fault;
    ev[`LPFS_ST_RUN] = det_done && !any_short && !fault;
  end

  // sticky status; a new event beats the read clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      status <= '0;
    end else begin
      // only bits already reported are cleared, so an event in the wait cycle survives
      status <= (rd_clear ? status & ~avs_readdata[`LPFS_EV_W-1:0] : status) | ev;
    end
  end

  // level interrupt, one cycle behind status
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask[`LPFS_EV_W-1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave

  // every access waits exactly one cycle, which also registers readdata
  assign bus_go = (avs_read || avs_write) && !avs_waitrequest;
  assign rd_clear = bus_go && avs_read && (avs_address == `LPFS_ADDR_STATUS);

  // wait state generator
  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // writable registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= `LPFS_CTRL_RST;
      mask <= `LPFS_MASK_RST;
    end else if (bus_go && avs_write) begin
      case (avs_address)
        `LPFS_ADDR_CTRL: begin
          ctrl <= {30'h0, avs_writedata[1:0]};
        end
        `LPFS_ADDR_MASK: begin
          mask <= {26'h0, avs_writedata[`LPFS_EV_W-1:0]};
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // read data settles while waitrequest is still high
  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `LPFS_ADDR_CTRL: begin
          avs_readdata <= ctrl;
        end
        `LPFS_ADDR_STATUS: begin
          avs_readdata <= {26'h0, status};
        end
        `LPFS_ADDR_MASK: begin
          avs_readdata <= mask;
        end
        `LPFS_ADDR_STATE: begin
          avs_readdata <= {16'h0, pin_short, pin_used, 2'b00, state};
        end
        default: begin
          avs_readdata <= '0;
        end
      endcase
    end
  end

endmodule
